// ===== logic/arsr_ctrl.sv
// converter result packing, sleep behaviour and reset control
`include "arsr_consts.svh"
// Operation
// (R1) completion loads result into 16-bit pair
// (R2) format bit picks left or right justification
// (R3) unused six result bits loaded as zero
// (R4) disabled converter: result bytes are plain storage
// (R5) conversion survives sleep only with RC clock
// (R6) RC clock delays start by one instruction
// (R7) completion clears go and loads result
// (R8) completion in sleep with interrupt wakes device
// (R9) completion in sleep without interrupt powers down
// (R10) non-RC clock: sleep aborts and powers down
// (R11) software sleeps right after setting go
// (R12) reset clears control, stops converter, aborts
// (R13) reset never touches the result pair
// (R14) core done pulse carries raw value, captured
// (R15) format one is right, zero is left
module arsr_ctrl #(
  parameter int TCY_CLKS = `ARSR_TCY_CLKS,
  parameter int CNT_W    = `ARSR_CNT_W
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [`ARSR_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]             regWrData,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic [7:0]                  regRdData,
  input  wire logic                   sleepReq,
  output logic                        wakeReq,
  output logic                        irq,
  output logic                        convStart,
  output logic                        convAbort,
  output logic                        corePowerOn,
  input  wire logic                   coreDone,
  input  wire logic [`ARSR_RAW_W-1:0] coreData
);
  localparam int TcyChk = TCY_CLKS;

  logic                   rstMeta_q;
  logic                   rstN;
  arsr_pkg::arsr_state_t  state_q;
  arsr_pkg::arsr_state_t  state_d;
  logic [7:0]             ctrl_q;
  logic [7:0]             ctrl_d;
  logic                   go_q;
  logic                   go_d;
  logic                   powerDown_q;
  logic                   powerDown_d;
  logic                   wake_q;
  logic                   wake_d;
  logic [`ARSR_EVT_W-1:0] status_q;
  logic [`ARSR_EVT_W-1:0] status_d;
  logic [`ARSR_EVT_W-1:0] mask_q;
  logic [7:0]             rdData_q;
  logic [7:0]             rdData_d;
  arsr_pkg::arsr_byte_t   resHigh;
  arsr_pkg::arsr_byte_t   resLow;

  // reset release through two flops; the first is read only by the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  // register decode
  wire ctrlWr   = regWr && (regAddr == `ARSR_REG_CTRL);
  wire resHiWr  = regWr && (regAddr == `ARSR_REG_RES_HI);
  wire resLoWr  = regWr && (regAddr == `ARSR_REG_RES_LO);
  wire statusWr = regWr && (regAddr == `ARSR_REG_STATUS);
  wire maskWr   = regWr && (regAddr == `ARSR_REG_MASK);

  // clock select decode, shared by the live and the freshly written control byte
  function automatic logic isRcSel(input logic [7:0] ctlByte);
    return ctlByte[`ARSR_CTRL_CS_HI:`ARSR_CTRL_CS_LO] == `ARSR_CS_RC;
  endfunction

  // control fields
  wire ctrlOn    = ctrl_q[`ARSR_CTRL_ON];
  wire rcClock   = isRcSel(ctrl_q); // R5
  wire rightJust = ctrl_q[`ARSR_CTRL_JUST]; // R15
  wire irqEnable = mask_q[`ARSR_EVT_DONE];
  wire wrOn      = regWrData[`ARSR_CTRL_ON];
  wire wrGo      = regWrData[`ARSR_CTRL_GO];
  wire wrRc      = isRcSel(regWrData);

  // sequencing events
  wire idle       = state_q == arsr_pkg::ARSR_IDLE;
  wire busy       = !idle;
  wire goStart    = ctrlWr && wrOn && wrGo && idle && !powerDown_q && !sleepReq;
  wire doneLoad   = coreDone && (state_q == arsr_pkg::ARSR_CONV); // R14
  wire offAbort   = ctrlWr && !wrOn && busy;
  wire sleepAbort = sleepReq && !rcClock && busy; // R10
  wire anyAbort   = offAbort || sleepAbort;
  wire delayFire;

  // the RC clock waits one instruction cycle so the sleep can settle first
  wire [CNT_W-1:0] startCount = wrRc ? CNT_W'(TCY_CLKS) : CNT_W'(`ARSR_CNT_ONE); // R6

  arsr_start_delay #(
    .CNT_W (CNT_W)
  ) u_delay (
    .clk     (clk),
    .rstN    (rstN),
    .load    (goStart),
    .loadVal (startCount),
    .cancel  (anyAbort),
    .fire    (delayFire)
  );

  // conversion handshake toward the analog core
  assign convStart   = delayFire && (state_q == arsr_pkg::ARSR_DELAY) && !anyAbort; // R6
  assign convAbort   = anyAbort && (state_q == arsr_pkg::ARSR_CONV); // R10 R12
  assign corePowerOn = ctrlOn && !powerDown_q; // R9 R10

  // state sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      arsr_pkg::ARSR_IDLE: begin
        if (goStart) begin
          state_d = arsr_pkg::ARSR_DELAY;
        end
      end
      arsr_pkg::ARSR_DELAY: begin
        if (anyAbort) begin
          state_d = arsr_pkg::ARSR_IDLE;
        end else if (delayFire) begin
          state_d = arsr_pkg::ARSR_CONV;
        end
      end
      arsr_pkg::ARSR_CONV: begin
        if (anyAbort || doneLoad) begin // R5 R10
          state_d = arsr_pkg::ARSR_IDLE;
        end
      end
      default: begin
        state_d = arsr_pkg::ARSR_IDLE;
      end
    endcase
  end

  // control byte: go is kept apart since hardware clears it
  assign ctrl_d = ctrlWr ? (regWrData & ~(8'h01 << `ARSR_CTRL_GO)) : ctrl_q;
  assign go_d   = goStart ? 1'b1 : ((doneLoad || anyAbort) ? 1'b0 : go_q); // R7

  // converter stays off through sleep once a non-RC sleep or a quiet finish hit it
  assign powerDown_d = sleepReq && (powerDown_q || !rcClock          // R10
                                    || (doneLoad && !irqEnable));    // R9

  // wake request holds until the sleep controller drops its request
  assign wake_d = sleepReq && (wake_q || (doneLoad && irqEnable)); // R8

  // sticky events, hardware set wins over a write-one clear
  wire [`ARSR_EVT_W-1:0] evtSet = {anyAbort, doneLoad};
  wire [`ARSR_EVT_W-1:0] evtClr = statusWr ? regWrData[`ARSR_EVT_W-1:0] : `ARSR_EVT_RST;
  assign status_d = (status_q & ~evtClr) | evtSet;
  assign irq      = |(status_q & mask_q);

  // read selection; unmapped offsets read zero
  wire [7:0] stateByte = {4'h0, powerDown_q, sleepReq, state_q};
  wire [7:0] ctrlByte  = ctrl_q | ({7'h00, go_q} << `ARSR_CTRL_GO);
  wire [7:0] readMux =
    (regAddr == `ARSR_REG_CTRL)   ? ctrlByte :
    (regAddr == `ARSR_REG_RES_HI) ? resHigh :
    (regAddr == `ARSR_REG_RES_LO) ? resLow :
    (regAddr == `ARSR_REG_STATUS) ? {6'h00, status_q} :
    (regAddr == `ARSR_REG_MASK)   ? {6'h00, mask_q} :
    (regAddr == `ARSR_REG_STATE)  ? stateByte : `ARSR_BYTE_ZERO;
  assign rdData_d  = regRd ? readMux : `ARSR_BYTE_ZERO;
  assign regRdData = rdData_q;
  assign wakeReq   = wake_q;

  // control state; reset clears it all and so aborts any conversion
  always_ff @(posedge clk or negedge rstN) begin // R12
    if (!rstN) begin
      state_q     <= arsr_pkg::ARSR_IDLE;
      ctrl_q      <= `ARSR_CTRL_RST;
      go_q        <= 1'b0;
      powerDown_q <= 1'b0;
      wake_q      <= 1'b0;
      status_q    <= `ARSR_EVT_RST;
      mask_q      <= `ARSR_EVT_RST;
      rdData_q    <= `ARSR_BYTE_ZERO;
    end else begin
      state_q     <= state_d;
      ctrl_q      <= ctrl_d;
      go_q        <= go_d;
      powerDown_q <= powerDown_d;
      wake_q      <= wake_d;
      status_q    <= status_d;
      mask_q      <= maskWr ? regWrData[`ARSR_EVT_W-1:0] : mask_q;
      rdData_q    <= rdData_d;
    end
  end

  // result pair; software writes land only while the converter is off
  arsr_result_store u_store (
    .clk       (clk),
    .load      (doneLoad), // R1 R7
    .raw       (coreData),
    .rightJust (rightJust),
    .wrHigh    (resHiWr && !ctrlOn), // R4
    .wrLow     (resLoWr && !ctrlOn), // R4
    .wrData    (regWrData),
    .resHigh   (resHigh),
    .resLow    (resLow)
  );

  // justified result with zero fill, as the pair must hold it after a load
  function automatic logic [15:0] packResult(input logic [`ARSR_RAW_W-1:0] rawVal,
                                             input logic                     rightSel);
    return rightSel ? {`ARSR_FILL_ZERO, rawVal} : {rawVal, `ARSR_FILL_ZERO};
  endfunction

  // expected pair for checking
  wire [15:0] expPair = packResult(coreData, rightJust);

  sequence startSeq;
    goStart ##TcyChk convStart;
  endsequence

  sequence abortSeq;
    convAbort || (state_q == arsr_pkg::ARSR_DELAY) ##1 idle && !go_q && !corePowerOn;
  endsequence

  result_load_a: assert property (@(posedge clk) disable iff (!rstN) // R1
    doneLoad |=> {resHigh, resLow} == $past(expPair))
    else $error("result pair does not match the completed conversion");

  justify_sel_a: assert property (@(posedge clk) disable iff (!rstN) // R2
    doneLoad && !rightJust |=> resHigh == $past(coreData[`ARSR_RAW_W-1 -: 8]))
    else $error("left justified high byte wrong");

  gp_storage_a: assert property (@(posedge clk) disable iff (!rstN) // R4
    resLoWr && !ctrlOn && !doneLoad |=> resLow == $past(regWrData))
    else $error("result low byte did not store written value");

  rc_sleep_a: assert property (@(posedge clk) disable iff (!rstN) // R5
    state_q == arsr_pkg::ARSR_CONV && sleepReq && rcClock && !coreDone && !ctrlWr
      |=> state_q == arsr_pkg::ARSR_CONV)
    else $error("RC conversion did not survive sleep");

  start_delay_a: assert property (@(posedge clk) disable iff (!rstN) // R6
    goStart && wrRc && !sleepReq |-> ##TcyChk (convStart || !ctrlOn || sleepReq))
    else $error("RC start not delayed by one instruction cycle");

  go_clear_a: assert property (@(posedge clk) disable iff (!rstN) // R7
    doneLoad |=> !go_q && status_q[`ARSR_EVT_DONE])
    else $error("completion did not clear go and flag done");

  wake_req_a: assert property (@(posedge clk) disable iff (!rstN) // R8
    doneLoad && sleepReq && irqEnable ##1 sleepReq |-> wakeReq && corePowerOn == ctrlOn)
    else $error("completion in sleep did not request wake-up");

  sleep_off_a: assert property (@(posedge clk) disable iff (!rstN) // R9
    doneLoad && sleepReq && !irqEnable && !ctrlWr |=> !corePowerOn && ctrlOn && !wakeReq)
    else $error("quiet completion in sleep did not power down");

  sleep_abort_a: assert property (@(posedge clk) disable iff (!rstN) // R10
    sleepAbort && !ctrlWr |-> abortSeq ##0 ctrlOn)
    else $error("non-RC sleep did not abort and power down");

  reset_clean_a: assert property (@(posedge clk) // R12
    $rose(rstN) |-> idle && ctrl_q == `ARSR_CTRL_RST && !go_q && !corePowerOn)
    else $error("reset left converter control active");

  start_cover_seq_a: assert property (@(posedge clk) disable iff (!rstN) // R6
    goStart && !wrRc |-> ##1 (convStart || anyAbort))
    else $error("non-RC start not issued on the next cycle");

  unused_seq_a: assert property (@(posedge clk) disable iff (!rstN) // R6
    startSeq |-> ##1 state_q == arsr_pkg::ARSR_CONV)
    else $error("conversion state not entered after start");

  start_idle_a: assert property (@(posedge clk) disable iff (!rstN) // R6
    goStart |=> state_q == arsr_pkg::ARSR_DELAY && go_q)
    else $error("go request did not enter the start delay");

  start_go_a: assert property (@(posedge clk) disable iff (!rstN) // R6
    convStart |-> go_q)
    else $error("conversion started without a pending go");

  conv_enter_a: assert property (@(posedge clk) disable iff (!rstN) // R6
    convStart |=> state_q == arsr_pkg::ARSR_CONV && go_q)
    else $error("start pulse did not enter conversion");

  // interrupt and status flags; a hardware set beats a software clear
  irq_done_a: assert property (@(posedge clk) disable iff (!rstN) // R8
    doneLoad && irqEnable && !maskWr |=> irq)
    else $error("unmasked completion did not raise the interrupt");

  status_hold_a: assert property (@(posedge clk) disable iff (!rstN) // R7
    status_q[`ARSR_EVT_DONE] && !statusWr |=> status_q[`ARSR_EVT_DONE])
    else $error("done flag dropped without a clear");

  status_clear_a: assert property (@(posedge clk) disable iff (!rstN) // R7
    statusWr && regWrData[`ARSR_EVT_DONE] && !doneLoad |=> !status_q[`ARSR_EVT_DONE])
    else $error("done flag not cleared by a written one");

  abort_flag_a: assert property (@(posedge clk) disable iff (!rstN) // R10
    anyAbort |=> idle && !go_q && status_q[`ARSR_EVT_ABORT])
    else $error("abort did not stop the conversion and flag it");

  // converter power and wake-up through sleep
  sleep_power_a: assert property (@(posedge clk) disable iff (!rstN) // R10
    sleepReq && !rcClock |=> !corePowerOn)
    else $error("sleep with another clock left the converter powered");

  rc_power_a: assert property (@(posedge clk) disable iff (!rstN) // R5
    sleepReq && rcClock && !powerDown_q && !doneLoad |=> corePowerOn == ctrlOn)
    else $error("RC sleep powered the converter down early");

  power_restore_a: assert property (@(posedge clk) disable iff (!rstN) // R9
    !sleepReq |=> corePowerOn == ctrlOn)
    else $error("converter power not restored after sleep");

  wake_hold_a: assert property (@(posedge clk) disable iff (!rstN) // R8
    wakeReq && sleepReq |=> wakeReq)
    else $error("wake request dropped while still asleep");

  wake_drop_a: assert property (@(posedge clk) disable iff (!rstN) // R8
    !sleepReq |=> !wakeReq)
    else $error("wake request held outside sleep");

  // reset and register port behaviour
  reset_off_a: assert property (@(posedge clk) // R12
    !rstN |-> !corePowerOn && !convStart && !wakeReq && !irq)
    else $error("converter active during reset");

  no_wr_on_a: assert property (@(posedge clk) disable iff (!rstN) // R4
    resHiWr && ctrlOn && !doneLoad |=> $stable(resHigh))
    else $error("result high byte written while converter on");

  rd_zero_a: assert property (@(posedge clk) disable iff (!rstN) // R4
    !regRd |=> regRdData == `ARSR_BYTE_ZERO)
    else $error("read data not zero outside a read");

  rd_result_a: assert property (@(posedge clk) disable iff (!rstN) // R4
    regRd && regAddr == `ARSR_REG_RES_HI |=> regRdData == $past(resHigh))
    else $error("result high byte read back wrong");
endmodule

// ===== inc/arsr_consts.svh
// constants of the converter result, sleep and reset controller
`ifndef ARSR_CONSTS_SVH
`define ARSR_CONSTS_SVH
`define ARSR_ADDR_W      3
`define ARSR_REG_CTRL    3'h0
`define ARSR_REG_RES_HI  3'h1
`define ARSR_REG_RES_LO  3'h2
`define ARSR_REG_STATUS  3'h3
`define ARSR_REG_MASK    3'h4
`define ARSR_REG_STATE   3'h5
`define ARSR_CTRL_ON     0
`define ARSR_CTRL_GO     1
`define ARSR_CTRL_CS_LO  2
`define ARSR_CTRL_CS_HI  3
`define ARSR_CTRL_JUST   4
`define ARSR_CS_RC       2'h3
`define ARSR_EVT_DONE    0
`define ARSR_EVT_ABORT   1
`define ARSR_EVT_W       2
`define ARSR_CTRL_RST    8'h00
`define ARSR_EVT_RST     2'h0
`define ARSR_BYTE_ZERO   8'h00
`define ARSR_RAW_W       10
`define ARSR_FILL_W      6
`define ARSR_FILL_ZERO   6'h00
`define ARSR_TCY_NS      40
`define ARSR_CLK_NS      10
`define ARSR_TCY_CLKS    ((`ARSR_TCY_NS + `ARSR_CLK_NS - 1) / `ARSR_CLK_NS)
`define ARSR_CNT_W       4
`define ARSR_CNT_ONE     4'h1
`endif

// ===== inc/arsr_pkg.sv
// types shared by the converter result, sleep and reset controller
package arsr_pkg;
  typedef enum logic [1:0] {ARSR_IDLE, ARSR_DELAY, ARSR_CONV} arsr_state_t;
  typedef logic [7:0] arsr_byte_t;
endpackage

// ===== logic/arsr_start_delay.sv
// start delay counter between the go request and the conversion start
`include "arsr_consts.svh"
module arsr_start_delay #(
  parameter int CNT_W = `ARSR_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] loadVal,
  input  wire logic             cancel,
  output logic                  fire
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             busy_q;
  logic             busy_d;

  // fires in the last counted cycle, so a load of n fires n cycles later
  assign fire  = busy_q && (cnt_q == CNT_W'(`ARSR_CNT_ONE));
  assign busy_d = load ? 1'b1 : ((cancel || fire) ? 1'b0 : busy_q);
  assign cnt_d = load ? loadVal : (busy_q ? cnt_q - CNT_W'(`ARSR_CNT_ONE) : cnt_q);

  // counter state
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end
endmodule

// ===== logic/arsr_result_store.sv
// result byte pair: loaded by conversions, plain storage otherwise
`include "arsr_consts.svh"
module arsr_result_store (
  input  wire logic                     clk,
  input  wire logic                     load,
  input  wire logic [`ARSR_RAW_W-1:0]   raw,
  input  wire logic                     rightJust,
  input  wire logic                     wrHigh,
  input  wire logic                     wrLow,
  input  wire logic [7:0]               wrData,
  output arsr_pkg::arsr_byte_t          resHigh,
  output arsr_pkg::arsr_byte_t          resLow
);
  logic [15:0] packed_w;

  // justified value with the spare bits filled with zeros
  assign packed_w = rightJust ? {`ARSR_FILL_ZERO, raw}   // R2 R3 R15
                              : {raw, `ARSR_FILL_ZERO};  // R2 R3

  // no reset on purpose: contents survive every reset, unknown after power-up
  always_ff @(posedge clk) begin // R13
    if (load) begin
      resHigh <= packed_w[15:8]; // R1
      resLow  <= packed_w[7:0];
    end else begin
      if (wrHigh) begin
        resHigh <= wrData; // R4
      end
      if (wrLow) begin
        resLow <= wrData; // R4
      end
    end
  end

  fill_right_a: assert property (@(posedge clk) // R3
    load && rightJust |=> {resHigh, resLow} >> `ARSR_RAW_W == 16'h0000)
    else $error("upper fill bits not zero after right justified load");
  fill_left_a: assert property (@(posedge clk) // R3
    load && !rightJust |=> resLow[`ARSR_FILL_W-1:0] == `ARSR_FILL_ZERO)
    else $error("lower fill bits not zero after left justified load");
endmodule

// ===== testbench/arsr_core_model.sv
// behavioural analog sample-and-convert core for the controller bench
module arsr_core_model (
  input  wire logic       clk,
  input  wire logic       convStart,
  input  wire logic       convAbort,
  input  wire logic       corePowerOn,
  input  wire logic [7:0] dly,
  input  wire logic [9:0] val,
  output logic            coreDone,
  output logic [9:0]      coreData
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = -1;
  initial coreDone = 1'b0;
  initial coreData = 10'h3FF;
  // count down from the start pulse; dropped power or abort kills the conversion
  always @(posedge clk) begin
    coreDone <= 1'b0;
    coreData <= ~coreData; // data toggles so a stale value never matches
    if (convAbort || !corePowerOn) cnt <= -1;
    else if (convStart) cnt <= dly;
    else if (cnt > 0) cnt <= cnt - 1;
    else if (cnt == 0) begin
      coreDone <= 1'b1;
      coreData <= val;
      cnt <= -1;
    end
  end
endmodule

// ===== testbench/tb_top.sv
// self-checking bench of the result, sleep and reset controller
`include "arsr_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TCY = 4;
  logic       clk, nrst, regWr, regRd, sleepReq;
  logic       wakeReq, irq, convStart, convAbort, corePowerOn, coreDone;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, dly;
  logic [9:0] coreData, val;
  int         err_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         lastE;
  int         expQ[$];

  arsr_ctrl #(.TCY_CLKS(TCY), .CNT_W(`ARSR_CNT_W)) arsr_ctrl_inst (.clk(clk), .nrst(nrst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sleepReq(sleepReq), .wakeReq(wakeReq), .irq(irq),
    .convStart(convStart), .convAbort(convAbort), .corePowerOn(corePowerOn),
    .coreDone(coreDone), .coreData(coreData));
  arsr_core_model arsr_core_model_inst (.clk(clk), .convStart(convStart),
    .convAbort(convAbort), .corePowerOn(corePowerOn), .dly(dly), .val(val),
    .coreDone(coreDone), .coreData(coreData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // a hung handshake ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data is looked at in the one cycle it stands
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(regRdData, exp);
  endtask

  task automatic waitStart(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (convStart !== 1'b1 && n < 50);
  endtask

  // one conversion: model returns a raw value, bench queues its justified form, result bytes compared
  task automatic conv(input logic [1:0] cs, input logic r, input logic slp);
    int n;
    logic [9:0] v;
    v = 10'($urandom);
    val <= v;
    dly <= 8'($urandom % 6 + 1);
    expQ.push_back(r ? int'(v) : int'(v) << 6);
    wr(`ARSR_REG_CTRL, {3'h0, r, cs, 2'h3});
    if (slp) sleepReq <= 1'b1;
    waitStart(n);
    chk(8'(n), 8'(cs == `ARSR_CS_RC ? TCY : 1));
    n = 0;
    while (coreDone !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n < 100), 8'h01);
    @(posedge clk);
    lastE = expQ.pop_front();
    rchk(`ARSR_REG_RES_HI, 8'(lastE >> 8));
    rchk(`ARSR_REG_RES_LO, 8'(lastE));
    rchk(`ARSR_REG_CTRL, {3'h0, r, cs, 2'h1});
  endtask

  initial begin
    int n;
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    sleepReq = 1'b0;
    regAddr = 3'h0;
    regWrData = 8'h00;
    dly = 8'h01;
    val = 10'h000;
    void'($urandom(20));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`ARSR_REG_CTRL, 8'h00);
    rchk(`ARSR_REG_STATUS, 8'h00);
    chk(corePowerOn, 1'b0);
    // result bytes are plain storage while the converter is off; a hole reads zero
    wr(`ARSR_REG_RES_HI, 8'hA5);
    wr(`ARSR_REG_RES_LO, 8'h5A);
    wr(3'h7, 8'hFF);
    rchk(`ARSR_REG_RES_HI, 8'hA5);
    rchk(`ARSR_REG_RES_LO, 8'h5A);
    rchk(3'h7, 8'h00);
    // every clock select with both justifications, done interrupt unmasked
    wr(`ARSR_REG_MASK, 8'h01);
    for (int i = 0; i < 8; i++) conv(2'(i), 1'(i / 4), 1'b0);
    @(negedge clk);
    chk(irq, 1'b1);
    wr(`ARSR_REG_STATUS, 8'h01);
    @(negedge clk);
    chk(irq, 1'b0);
    // while the converter is on the result bytes refuse writes
    wr(`ARSR_REG_RES_HI, 8'(~(lastE >> 8)));
    rchk(`ARSR_REG_RES_HI, 8'(lastE >> 8));
    // sleep with the RC clock and the interrupt enabled wakes the device
    conv(2'h3, 1'b1, 1'b1);
    @(negedge clk);
    chk(wakeReq, 1'b1);
    @(posedge clk);
    sleepReq <= 1'b0;
    // sleep with the interrupt off powers the core down, on-bit kept
    wr(`ARSR_REG_MASK, 8'h02);
    conv(2'h3, 1'b0, 1'b1);
    chk(corePowerOn, 1'b0);
    chk(wakeReq, 1'b0);
    @(posedge clk);
    sleepReq <= 1'b0;
    // sleep with another clock aborts a running conversion
    wr(`ARSR_REG_STATUS, 8'h03);
    dly <= 8'h40;
    wr(`ARSR_REG_CTRL, 8'h03);
    waitStart(n);
    @(posedge clk);
    sleepReq <= 1'b1;
    @(negedge clk);
    chk(convAbort, 1'b1);
    @(negedge clk);
    chk(corePowerOn, 1'b0);
    chk(irq, 1'b1);
    rchk(`ARSR_REG_STATUS, 8'h02);
    rchk(`ARSR_REG_CTRL, 8'h01);
    @(posedge clk);
    sleepReq <= 1'b0;
    // reset in mid-conversion clears control but keeps the result pair
    wr(`ARSR_REG_CTRL, 8'h0F);
    waitStart(n);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`ARSR_REG_CTRL, 8'h00);
    chk(corePowerOn, 1'b0);
    rchk(`ARSR_REG_RES_HI, 8'(lastE >> 8));
    rchk(`ARSR_REG_RES_LO, 8'(lastE));
    test_done();
  end
endmodule
